// ===== alal_pkg.sv
package alal_pkg;

    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned TENTH_NS      = 100_000_000;
    // one tenth of a second, rounded up to whole clock cycles
    localparam int unsigned TENTH_CYCLES  = (TENTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned DELAY_W = 17;
    localparam int unsigned INT_W   = 3;

    localparam logic [7:0] CTRL_OFS       = 8'h00;
    localparam logic [7:0] DELAY_OFS      = 8'h04;
    localparam logic [7:0] THRESHOLD_OFS  = 8'h08;
    localparam logic [7:0] HYSTERESIS_OFS = 8'h0c;
    localparam logic [7:0] ACK_OFS        = 8'h10;
    localparam logic [7:0] STATUS_OFS     = 8'h14;
    localparam logic [7:0] INT_STATUS_OFS = 8'h18;
    localparam logic [7:0] INT_CLEAR_OFS  = 8'h1c;
    localparam logic [7:0] INT_ENABLE_OFS = 8'h20;

    localparam int unsigned CTRL_LATCH_LSB    = 0;
    localparam int unsigned CTRL_BLOCK_BIT    = 2;
    localparam int unsigned CTRL_SUPPRESS_BIT = 3;
    localparam int unsigned CTRL_STANDBY_BIT  = 4;
    localparam int unsigned ACK_BIT           = 0;
    localparam int unsigned STAT_CODE_LSB     = 0;
    localparam int unsigned STAT_OUT_BIT      = 2;
    localparam int unsigned STAT_TRIP_BIT     = 3;
    localparam int unsigned STAT_BLOCKED_BIT  = 4;
    localparam int unsigned INT_RAISE_BIT     = 0;
    localparam int unsigned INT_DROP_BIT      = 1;
    localparam int unsigned INT_ACK_BIT       = 2;

    localparam logic [DELAY_W-1:0] DELAY_RST      = 17'h0_0000;
    localparam logic [31:0]        THRESHOLD_RST  = 32'h0000_000a;
    localparam logic [31:0]        HYSTERESIS_RST = 32'h0000_0000;
    localparam logic [INT_W-1:0]   INT_ENABLE_RST = 3'h0;

    typedef enum logic [1:0] {
        latch_none       = 2'b00,
        latch_auto       = 2'b01,
        latch_manual     = 2'b10,
        latch_event_only = 2'b11
    } alal_latch_t;

    typedef enum logic [1:0] {
        st_off                = 2'b00,
        st_active_acked       = 2'b01,
        cleared_unacked_state = 2'b10,
        st_active_unacked     = 2'b11
    } alal_status_t;

    function automatic logic is_latching(input alal_latch_t lt);
        is_latching = (lt == latch_auto) || (lt == latch_manual);
    endfunction

endpackage

// ===== alal_delay_if.sv
interface alal_delay_if;
    import alal_pkg::*;
    logic               tick;
    logic               trig;
    logic [DELAY_W-1:0] delay;
    logic               qual;

    modport ctrl (output tick, output trig, output delay, input qual);
    modport timer (input tick, input trig, input delay, output qual);
endinterface

// ===== alal_delay.sv
module alal_delay
    import alal_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    alal_delay_if.timer dly
);

    logic [DELAY_W-1:0] count_q;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !dly.trig) begin
            count_q <= '0;                                      // [RULE7]
        end else if (dly.tick && (count_q < dly.delay)) begin
            count_q <= count_q + 17'h0_0001;                    // [RULE16]
        end
    end

    // zero delay passes the trigger straight through
    assign dly.qual = dly.trig && ((dly.delay == DELAY_RST) || (count_q >= dly.delay)); // [RULE7] [RULE8]

endmodule

// ===== alal_top.sv
// Functional notes
// [RULE1] none: alarm drops when condition clears
// [RULE2] auto: hold until cleared and acked
// [RULE3] manual: ack ignored while condition present
// [RULE4] event: like none, no annunciation
// [RULE5] blocking suppresses alarm until first healthy
// [RULE6] unacked latch reasserts; threshold change reblocks
// [RULE7] alarm only after continuous trigger delay
// [RULE8] zero delay disables the timer
// [RULE9] output high whenever status not off
// [RULE10] ack written one, self clears to zero
// [RULE11] suppress forces status off
// [RULE12] after suppress, re-evaluate from trigger
// [RULE13] standby suppress acts like direct suppress
// [RULE14] status codes 0..3, off while suppressed
// [RULE15] high trip with hysteresis release point
// [RULE16] tenth-second tick, reset clears to off
module alal_top
    import alal_pkg::*;
#(
    parameter int unsigned TENTH_CYCLES_P = TENTH_CYCLES
) (
    input  wire logic                mclk_i,
    input  wire logic                sys_rst_i,
    input  wire logic [ADDR_W-1:0]   addr_i,
    input  wire logic [DATA_W-1:0]   wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic      [DATA_W-1:0]   rdata_o,
    input  wire logic signed [31:0]  pv_i,
    input  wire logic                standby_i,
    output logic      [1:0]          status_o,
    output logic                     alarm_out_o,
    output logic                     annunciate_o,
    output logic                     irq_o
);

    alal_delay_if dly ();

    alal_latch_t          latch_q;
    logic                 block_en_q;
    logic                 suppress_q;
    logic                 standby_suppress_q;
    logic [DELAY_W-1:0]   delay_q;
    logic signed [31:0]   trip_threshold_q;
    logic signed [31:0]   switch_hysteresis_q;
    logic                 ack_q;
    logic                 threshold_wr;
    logic [24:0]          div_q;
    logic                 tick;
    logic                 trip_q;
    logic                 blocked_q;
    alal_status_t         state_q;
    alal_status_t         state_d;
    logic                 suppressed;
    logic                 latched_unacked;
    logic                 block_gate;
    logic                 trig_eff;
    logic                 ack_ok;
    logic [INT_W-1:0]     int_status_q;
    logic [INT_W-1:0]     int_enable_q;
    logic [INT_W-1:0]     int_events;
    logic [INT_W-1:0]     int_clear;
    logic                 alarm_out_q;
    logic                 annunciate_q;
    logic [DATA_W-1:0]    rdata_q;
    logic signed [32:0]   release_level;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign threshold_wr = wr_i && hit(addr_i, THRESHOLD_OFS);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            latch_q            <= latch_none;                   // [RULE1]
            block_en_q         <= 1'b0;                         // [RULE5]
            suppress_q         <= 1'b0;                         // [RULE11]
            standby_suppress_q <= 1'b0;
        end else if (wr_i && hit(addr_i, CTRL_OFS)) begin
            latch_q            <= alal_latch_t'(wdata_i[CTRL_LATCH_LSB +: 2]);
            block_en_q         <= wdata_i[CTRL_BLOCK_BIT];
            suppress_q         <= wdata_i[CTRL_SUPPRESS_BIT];
            standby_suppress_q <= wdata_i[CTRL_STANDBY_BIT];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            delay_q <= DELAY_RST;                               // [RULE8]
        end else if (wr_i && hit(addr_i, DELAY_OFS)) begin
            delay_q <= wdata_i[DELAY_W-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            trip_threshold_q    <= THRESHOLD_RST;
            switch_hysteresis_q <= HYSTERESIS_RST;
        end else begin
            if (threshold_wr) begin
                trip_threshold_q <= wdata_i;
            end
            if (wr_i && hit(addr_i, HYSTERESIS_OFS)) begin
                switch_hysteresis_q <= wdata_i;
            end
        end
    end

    // the ack bit lives for exactly one cycle, so a read never sees it stuck at one
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wr_i && hit(addr_i, ACK_OFS) && wdata_i[ACK_BIT]; // [RULE10]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 25'h000_0001;
        end
    end

    assign tick = (div_q == 25'(TENTH_CYCLES_P - 1));          // [RULE16]

    // widened so threshold minus hysteresis cannot wrap
    assign release_level = 33'(trip_threshold_q) - 33'(switch_hysteresis_q);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            trip_q <= 1'b0;
        end else if (pv_i > trip_threshold_q) begin
            trip_q <= 1'b1;                                     // [RULE15]
        end else if (33'(pv_i) < release_level) begin
            trip_q <= 1'b0;                                     // [RULE15]
        end
    end

    assign dly.tick  = tick;
    assign dly.trig  = trip_q;
    assign dly.delay = delay_q;

    alal_delay u_delay (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .dly       (dly)
    );

    assign suppressed = suppress_q || (standby_i && standby_suppress_q); // [RULE11] [RULE13]

    assign latched_unacked = is_latching(latch_q) &&
                             ((state_q == st_active_unacked) ||
                              (state_q == cleared_unacked_state));

    // a pending unacknowledged latch is shown even while blocked
    assign block_gate = block_en_q && blocked_q && !latched_unacked; // [RULE5] [RULE6]
    assign trig_eff   = dly.qual && !block_gate;

    // manual latching only honours ack once the condition is gone
    assign ack_ok = ack_q && ((latch_q != latch_manual) || !trig_eff); // [RULE2] [RULE3]

    // blocking restarts on reset and on a threshold change; released once healthy
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            blocked_q <= 1'b1;                                  // [RULE5]
        end else if (threshold_wr) begin
            blocked_q <= 1'b1;                                  // [RULE6]
        end else if (!trip_q) begin
            blocked_q <= 1'b0;                                  // [RULE5]
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            st_off: begin
                if (trig_eff) begin
                    state_d = st_active_unacked;                // [RULE7] [RULE12]
                end
            end
            st_active_unacked: begin
                if (!trig_eff) begin
                    if (is_latching(latch_q) && !ack_ok) begin
                        state_d = cleared_unacked_state;        // [RULE2] [RULE3]
                    end else begin
                        state_d = st_off;                       // [RULE1] [RULE4]
                    end
                end else if (ack_ok) begin
                    state_d = st_active_acked;                  // [RULE2]
                end
            end
            st_active_acked: begin
                if (!trig_eff) begin
                    state_d = st_off;
                end
            end
            cleared_unacked_state: begin
                if (trig_eff) begin
                    state_d = st_active_unacked;
                end else if (ack_ok) begin
                    state_d = st_off;                           // [RULE2] [RULE3]
                end
            end
            default: begin
                state_d = st_off;
            end
        endcase
        if (block_en_q && threshold_wr) begin
            state_d = st_off;                                   // [RULE6]
        end
        if (suppressed) begin
            state_d = st_off;                                   // [RULE11] [RULE12] [RULE14]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_q <= st_off;                                  // [RULE16]
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            alarm_out_q  <= 1'b0;
            annunciate_q <= 1'b0;
        end else begin
            alarm_out_q  <= (state_d != st_off);                // [RULE9]
            annunciate_q <= (state_d != st_off) && (latch_q != latch_event_only); // [RULE4]
        end
    end

    always_comb begin
        int_events = '0;
        int_events[INT_RAISE_BIT] = (state_q != st_active_unacked) &&
                                    (state_d == st_active_unacked);
        int_events[INT_DROP_BIT]  = (state_q != st_off) && (state_d == st_off);
        int_events[INT_ACK_BIT]   = ack_ok && ((state_q == st_active_unacked) ||
                                               (state_q == cleared_unacked_state));
    end

    assign int_clear = (wr_i && hit(addr_i, INT_CLEAR_OFS)) ? wdata_i[INT_W-1:0] : '0;

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            int_status_q <= '0;
        end else begin
            int_status_q <= (int_status_q & ~int_clear) | int_events;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            int_enable_q <= INT_ENABLE_RST;
        end else if (wr_i && hit(addr_i, INT_ENABLE_OFS)) begin
            int_enable_q <= wdata_i[INT_W-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_q <= '0;
        end else if (rd_i) begin
            rdata_q <= '0;
            case (addr_i)
                CTRL_OFS: begin
                    rdata_q[CTRL_LATCH_LSB +: 2]  <= latch_q;
                    rdata_q[CTRL_BLOCK_BIT]       <= block_en_q;
                    rdata_q[CTRL_SUPPRESS_BIT]    <= suppress_q;
                    rdata_q[CTRL_STANDBY_BIT]     <= standby_suppress_q;
                end
                DELAY_OFS: begin
                    rdata_q[DELAY_W-1:0] <= delay_q;
                end
                THRESHOLD_OFS: begin
                    rdata_q <= trip_threshold_q;
                end
                HYSTERESIS_OFS: begin
                    rdata_q <= switch_hysteresis_q;
                end
                ACK_OFS: begin
                    rdata_q[ACK_BIT] <= ack_q;                  // [RULE10]
                end
                STATUS_OFS: begin
                    rdata_q[STAT_CODE_LSB +: 2] <= state_q;     // [RULE14]
                    rdata_q[STAT_OUT_BIT]       <= alarm_out_q;
                    rdata_q[STAT_TRIP_BIT]      <= trip_q;
                    rdata_q[STAT_BLOCKED_BIT]   <= blocked_q;
                end
                INT_STATUS_OFS: begin
                    rdata_q[INT_W-1:0] <= int_status_q;
                end
                INT_ENABLE_OFS: begin
                    rdata_q[INT_W-1:0] <= int_enable_q;
                end
                default: begin
                    rdata_q <= '0;
                end
            endcase
        end
    end

    assign rdata_o      = rdata_q;
    assign status_o     = state_q;
    assign alarm_out_o  = alarm_out_q;
    assign annunciate_o = annunciate_q;
    assign irq_o        = |(int_status_q & int_enable_q);

endmodule

// ===== alal_checker.sv
module alal_checker
    import alal_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    input  wire logic [DATA_W-1:0] rdata_o,
    input  wire logic              standby_i,
    input  wire logic [1:0]        status_o,
    input  wire logic              alarm_out_o,
    input  wire logic              annunciate_o,
    input  wire logic              irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0]       ctl_q;
    logic [INT_W-1:0] ien_q;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    // shadow copies of the settings, taken from the bus itself
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctl_q <= 5'h00;
            ien_q <= '0;
        end else if (wr_i && addr_i == CTRL_OFS) begin
            ctl_q <= wdata_i[4:0];
        end else if (wr_i && addr_i == INT_ENABLE_OFS) begin
            ien_q <= wdata_i[INT_W-1:0];
        end
    end

    a_out_status: assert property (alarm_out_o == (status_o != st_off))
        else $error("alarm output disagrees with status");
    a_annunc_sub: assert property (annunciate_o |-> alarm_out_o)
        else $error("annunciation without alarm");
    a_event_silent: assert property (ctl_q[1:0] == 2'h3 |=> !annunciate_o)
        else $error("event type annunciated");
    a_suppress_off: assert property (ctl_q[CTRL_SUPPRESS_BIT] |=> status_o == st_off)
        else $error("status not off while suppressed");
    a_standby_off: assert property (ctl_q[CTRL_STANDBY_BIT] && standby_i |=> !alarm_out_o)
        else $error("alarm while standby suppressed");
    a_no_inactive: assert property (!is_latching(alal_latch_t'(ctl_q[1:0])) &&
        status_o != cleared_unacked_state |=> status_o != cleared_unacked_state)
        else $error("cleared unacked state on non latching type");
    a_irq_mask: assert property (ien_q == '0 |-> !irq_o)
        else $error("interrupt while all masked");
    a_unmapped_zero: assert property (rd_i && (addr_i > INT_ENABLE_OFS ||
        addr_i == INT_CLEAR_OFS) |=> rdata_o == '0)
        else $error("unmapped read not zero");
    a_reset_off: assert property (@(posedge mclk_i) disable iff (1'b0)
        sys_rst_i |=> status_o == st_off && !irq_o)
        else $error("reset did not clear alarm");
endmodule

// ===== alal_top_tb.sv
module alal_top_tb
    import alal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] HI = 32'h0000_0014;
    logic        mclk, rst, wr, rd, sby, aout, ann, irq;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, pv;
    logic [1:0]  st;
    int          errors, total_checks, cyc;
    // latch type, status after ack while active, status once cleared
    logic [5:0]  rows [4] = '{6'h04, 6'h14, 6'h2e, 6'h34};
    logic [39:0] rtab [8] = '{{CTRL_OFS, 32'h0}, {DELAY_OFS, 32'h0}, {THRESHOLD_OFS, 32'ha},
        {HYSTERESIS_OFS, 32'h0}, {INT_ENABLE_OFS, 32'h0}, {STATUS_OFS, 32'h0},
        {INT_CLEAR_OFS, 32'h0}, {8'h40, 32'h0}};

    alal_top #(.TENTH_CYCLES_P(4)) DUT (.mclk_i(mclk), .sys_rst_i(rst), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pv_i(pv),
        .standby_i(sby), .status_o(st), .alarm_out_o(aout), .annunciate_o(ann),
        .irq_o(irq));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    // samples off the edge, then realigns so drivers stay on the edge
    task automatic chk_st(input logic [1:0] e);
        #1;
        total_checks++;
        if (st !== e || aout !== (e != 2'h0)) begin
            errors++;
            $display("BAD %0t status %h want %h", $time, st, e);
        end
        @(posedge mclk);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge mclk);
        wr <= 1'h0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd   <= 1'h1;
        @(posedge mclk);
        rd <= 1'h0;
        #1;
        chk(rdata, e);
        @(posedge mclk);
    endtask

    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end

    // whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        rst = 1'h1;
        wr = 1'h0;
        rd = 1'h0;
        sby = 1'h0;
        addr = 8'h00;
        wdata = 32'h0;
        pv = 32'h0;
        tick(12);
        rst <= 1'h0;
        @(posedge mclk);
        chk_st(st_off);
        foreach (rtab[i]) rd_chk(rtab[i][39:32], rtab[i][31:0]);
        $display("reset values done");
        foreach (rows[i]) begin
            wr_reg(CTRL_OFS, {30'h0, rows[i][5:4]});
            pv <= HI;
            tick(3);
            chk_st(st_active_unacked);
            rd_chk(STATUS_OFS, 32'hf);
            chk({31'h0, ann}, {31'h0, rows[i][5:4] != 2'h3});
            wr_reg(ACK_OFS, 32'h1);
            tick(3);
            chk_st(rows[i][3:2]);
            pv <= 32'h0;
            tick(3);
            chk_st(rows[i][1:0]);
            wr_reg(ACK_OFS, 32'h1);
            tick(3);
            chk_st(st_off);
        end
        $display("latch types done");
        rd_chk(INT_STATUS_OFS, 32'h7);
        wr_reg(INT_ENABLE_OFS, 32'h2);
        #1;
        chk({31'h0, irq}, 32'h1);
        @(posedge mclk);
        wr_reg(INT_CLEAR_OFS, 32'h7);
        rd_chk(INT_STATUS_OFS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("interrupts done");
        wr_reg(DELAY_OFS, 32'h3);
        pv <= HI;
        tick(5);
        pv <= 32'h0;
        tick(15);
        chk_st(st_off);
        pv <= HI;
        tick(5);
        chk_st(st_off);
        tick(12);
        chk_st(st_active_unacked);
        pv <= 32'h0;
        wr_reg(DELAY_OFS, 32'h0);
        tick(3);
        chk_st(st_off);
        $display("delay done");
        wr_reg(HYSTERESIS_OFS, 32'h5);
        pv <= HI;
        tick(3);
        pv <= 32'h8;
        tick(3);
        rd_chk(STATUS_OFS, 32'hf);
        pv <= 32'h0;
        tick(3);
        rd_chk(STATUS_OFS, 32'h0);
        $display("hysteresis done");
        wr_reg(CTRL_OFS, 32'h1);
        pv <= HI;
        tick(3);
        chk_st(st_active_unacked);
        wr_reg(CTRL_OFS, 32'h9);
        tick(2);
        chk_st(st_off);
        pv <= 32'h0;
        tick(3);
        pv <= HI;
        tick(3);
        chk_st(st_off);
        wr_reg(CTRL_OFS, 32'h1);
        tick(2);
        chk_st(st_active_unacked);
        sby <= 1'h1;
        wr_reg(CTRL_OFS, 32'h11);
        tick(2);
        chk_st(st_off);
        sby <= 1'h0;
        tick(2);
        chk_st(st_active_unacked);
        $display("suppress done");
        wr_reg(CTRL_OFS, 32'h5);
        // one idle edge so the write strobe is not lowered and raised in one step
        tick(1);
        wr_reg(THRESHOLD_OFS, 32'ha);
        tick(2);
        chk_st(st_off);
        rd_chk(STATUS_OFS, 32'h18);
        pv <= 32'h0;
        tick(3);
        pv <= HI;
        tick(3);
        chk_st(st_active_unacked);
        $display("blocking done");
        rst <= 1'h1;
        tick(2);
        rst <= 1'h0;
        @(posedge mclk);
        chk_st(st_off);
        rd_chk(CTRL_OFS, 32'h0);
        rd_chk(ACK_OFS, 32'h0);
        $display("mid run reset done");
        finish_test();
    end
endmodule

bind alal_top alal_checker u_chk (.mclk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .standby_i, .status_o, .alarm_out_o, .annunciate_o, .irq_o);
